// ===== inc/xcvr_ctl_pkg.sv
// Behaviour
// - In four-wire mode both line transmitter and receiver enables stay active regardless of dtr and ready.
// - After reset and until another mode is loaded the block runs in four-wire mode.
// - The dtr line is active low: asserted is a low level, unasserted a high level.
// - In two-wire echo mode the transmitter is off while dtr is asserted and on while it is unasserted.
// - In two-wire echo mode the receiver stays enabled so the port hears its own bytes.
// - In two-wire dtr-controlled mode the transmitter is on while dtr is unasserted and the receiver is on only while dtr is asserted.
// - In auto mode the transmitter is enabled while the controller's transmit-ready line is asserted.
// - In auto mode the receiver is off whenever the transmitter is on and on while transmit-ready is unasserted.
// - Mode select codes are 128 four-wire, 129 echo, 130 dtr-controlled, 131 auto, carried as 32 bits.
// - The configured mode is loaded into the enable logic on each port open with no other step.
package xcvr_ctl_pkg;

    // ----------------------------------------
    // mode select codes
    // ----------------------------------------
    localparam int MODE_W = 32;
    localparam logic [MODE_W-1:0] MODE_FOUR_WIRE = 32'h0000_0080;
    localparam logic [MODE_W-1:0] MODE_DTR_ECHO = 32'h0000_0081;
    localparam logic [MODE_W-1:0] MODE_DTR_CTRL = 32'h0000_0082;
    localparam logic [MODE_W-1:0] MODE_TX_AUTO = 32'h0000_0083;

    typedef enum logic [1:0] {
        XM_FOUR_WIRE = 2'b00,
        XM_DTR_ECHO = 2'b01,
        XM_DTR_CTRL = 2'b10,
        XM_TX_AUTO = 2'b11
    } xcvr_mode_t;

    // ----------------------------------------
    // signal groups
    // ----------------------------------------
    typedef struct packed {
        logic dtr_n;
        logic tx_ready_line;
    } ctl_in_t;

    typedef struct packed {
        logic tx_en;
        logic rx_en;
    } line_en_t;

    typedef struct packed {
        xcvr_mode_t mode;
        ctl_in_t sync1;
        ctl_in_t sync2;
        line_en_t en;
    } xcvr_state_t;

    localparam line_en_t EN_RESET = 2'b11;

endpackage

// ===== rtl/xcvr_enable_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module xcvr_enable_ctl
    import xcvr_ctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic port_open,
    input wire logic [MODE_W-1:0] mode_sel,
    input wire logic dtr_n,
    input wire logic tx_ready_line,
    output logic line_tx_en,
    output logic line_rx_en,
    output logic mode_bad
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    xcvr_state_t st_r;
    xcvr_state_t st_nxt;
    logic bad_r;
    logic bad_nxt;

    // check a mode code against the four known codes; false marks an unknown code
    function automatic logic code_ok(input logic [MODE_W-1:0] c);
        code_ok = (c == MODE_FOUR_WIRE) || (c == MODE_DTR_ECHO) ||
                  (c == MODE_DTR_CTRL) || (c == MODE_TX_AUTO);
    endfunction

    // enables for a mode from synchronised inputs
    function automatic line_en_t enables(input xcvr_mode_t m, input ctl_in_t s);
        line_en_t e;
        e = EN_RESET;
        case (m)
            XM_FOUR_WIRE: begin
                e = EN_RESET;
            end
            XM_DTR_ECHO: begin
                e.tx_en = s.dtr_n;
                e.rx_en = 1'b1;
            end
            XM_DTR_CTRL: begin
                e.tx_en = s.dtr_n;
                e.rx_en = ~s.dtr_n;
            end
            XM_TX_AUTO: begin
                e.tx_en = s.tx_ready_line;
                e.rx_en = ~s.tx_ready_line;
            end
            default: begin
                e = EN_RESET;
            end
        endcase
        enables = e;
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        bad_nxt = bad_r;
        st_nxt.sync1.dtr_n = dtr_n;
        st_nxt.sync1.tx_ready_line = tx_ready_line;
        st_nxt.sync2 = st_r.sync1;
        // load mode on each open; unknown codes keep the old mode
        if (port_open) begin
            if (code_ok(mode_sel)) begin
                st_nxt.mode = xcvr_mode_t'(mode_sel[1:0]);
                bad_nxt = 1'b0;
            end else begin
                bad_nxt = 1'b1;
            end
        end
        st_nxt.en = enables(st_r.mode, st_r.sync2);
    end

    // registers, reset to four-wire with both enables on
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{mode: XM_FOUR_WIRE, sync1: 2'b11, sync2: 2'b11, en: EN_RESET};
            bad_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            bad_r <= bad_nxt;
        end
    end

    assign line_tx_en = st_r.en.tx_en;
    assign line_rx_en = st_r.en.rx_en;
    assign mode_bad = bad_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_four;
        st_r.mode == XM_FOUR_WIRE;
    endsequence

    chk_four_wire_on: assert property (@(posedge clk) disable iff (rst)
        s_four |=> (line_tx_en && line_rx_en))
        else $error("four-wire enables not both on");

    chk_reset_mode: assert property (@(posedge clk)
        $fell(rst) |-> (st_r.mode == XM_FOUR_WIRE && line_tx_en && line_rx_en))
        else $error("not four-wire after reset");

    chk_echo_tx: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode == XM_DTR_ECHO) |=> (line_tx_en == $past(st_r.sync2.dtr_n)))
        else $error("echo tx does not follow dtr");

    chk_echo_rx: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode == XM_DTR_ECHO) |=> line_rx_en)
        else $error("echo rx off");

    chk_ctrl_excl: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode == XM_DTR_CTRL) |=> (line_rx_en == !$past(st_r.sync2.dtr_n) && line_tx_en != line_rx_en))
        else $error("dtr-controlled enables wrong");

    chk_auto_tx: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode == XM_TX_AUTO && st_r.sync2.tx_ready_line) |=> line_tx_en)
        else $error("auto tx not enabled");

    chk_auto_rx: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode == XM_TX_AUTO) |=> (line_rx_en == !line_tx_en))
        else $error("auto rx not exclusive");

    chk_open_load: assert property (@(posedge clk) disable iff (rst)
        (port_open && mode_sel == MODE_TX_AUTO) |=> (st_r.mode == XM_TX_AUTO))
        else $error("mode not loaded on open");

    chk_dtr_latency: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode == XM_DTR_ECHO && port_open == 1'b0 && !dtr_n) [*4] |=> !line_tx_en)
        else $error("low dtr did not disable tx");

    // ----------------------------------------
    // named steps for the single-step checks
    // ----------------------------------------
    sequence s_echo;
        st_r.mode == XM_DTR_ECHO;
    endsequence

    sequence s_ctrl;
        st_r.mode == XM_DTR_CTRL;
    endsequence

    sequence s_auto;
        st_r.mode == XM_TX_AUTO;
    endsequence

    sequence s_open_good;
        port_open && code_ok(mode_sel);
    endsequence

    sequence s_open_bad;
        port_open && !code_ok(mode_sel);
    endsequence

    // ----------------------------------------
    // mode load checks
    // ----------------------------------------
    // four-wire code selects four-wire
    chk_open_four: assert property (@(posedge clk) disable iff (rst)
        (port_open && mode_sel == MODE_FOUR_WIRE) |=> (st_r.mode == XM_FOUR_WIRE))
        else $error("four-wire code not loaded");

    // echo code selects echo mode
    chk_open_echo: assert property (@(posedge clk) disable iff (rst)
        (port_open && mode_sel == MODE_DTR_ECHO) |=> (st_r.mode == XM_DTR_ECHO))
        else $error("echo code not loaded");

    // dtr-controlled code selects its mode
    chk_open_ctrl: assert property (@(posedge clk) disable iff (rst)
        (port_open && mode_sel == MODE_DTR_CTRL) |=> (st_r.mode == XM_DTR_CTRL))
        else $error("dtr-controlled code not loaded");

    // unknown code raises the flag
    chk_bad_set: assert property (@(posedge clk) disable iff (rst)
        s_open_bad |=> mode_bad)
        else $error("unknown code not flagged");

    // unknown code leaves the mode alone
    chk_bad_keeps: assert property (@(posedge clk) disable iff (rst)
        s_open_bad |=> (st_r.mode == $past(st_r.mode)))
        else $error("unknown code changed the mode");

    // good code clears the flag
    chk_bad_clear: assert property (@(posedge clk) disable iff (rst)
        s_open_good |=> !mode_bad)
        else $error("good code left flag set");

    // flag only moves on an open
    chk_bad_hold: assert property (@(posedge clk) disable iff (rst)
        !port_open |=> (mode_bad == $past(mode_bad)))
        else $error("flag moved without open");

    // mode only moves on an open
    chk_mode_hold: assert property (@(posedge clk) disable iff (rst)
        !port_open |=> (st_r.mode == $past(st_r.mode)))
        else $error("mode moved without open");

    // sync flops and reset flag right after release
    chk_reset_sync: assert property (@(posedge clk)
        $fell(rst) |-> (st_r.sync1 == 2'b11 && st_r.sync2 == 2'b11 && !mode_bad))
        else $error("state not at reset values");

    // ----------------------------------------
    // control input checks
    // ----------------------------------------
    // first sync stage takes dtr
    chk_sync_dtr: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> (st_r.sync1.dtr_n == $past(dtr_n)))
        else $error("dtr first stage wrong");

    // first sync stage takes ready
    chk_sync_ready: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> (st_r.sync1.tx_ready_line == $past(tx_ready_line)))
        else $error("ready first stage wrong");

    // second stage follows the first
    chk_sync_second: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> (st_r.sync2 == $past(st_r.sync1)))
        else $error("second stage wrong");

    // dtr-controlled tx follows unasserted dtr
    chk_ctrl_tx: assert property (@(posedge clk) disable iff (rst)
        s_ctrl |=> (line_tx_en == $past(st_r.sync2.dtr_n)))
        else $error("dtr-controlled tx does not follow dtr");

    // auto tx follows ready
    chk_auto_tx_follow: assert property (@(posedge clk) disable iff (rst)
        s_auto |=> (line_tx_en == $past(st_r.sync2.tx_ready_line)))
        else $error("auto tx does not follow ready");

    // auto tx off without ready
    chk_auto_tx_off: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode == XM_TX_AUTO && !st_r.sync2.tx_ready_line) |=> !line_tx_en)
        else $error("auto tx on without ready");

    // auto rx on without ready
    chk_auto_rx_on: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode == XM_TX_AUTO && !st_r.sync2.tx_ready_line) |=> line_rx_en)
        else $error("auto rx off while idle");

    // some enable always on in two-wire modes
    chk_two_wire_any: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode != XM_FOUR_WIRE) |=> (line_tx_en || line_rx_en))
        else $error("both enables off");

    // echo rx stays on by mode
    chk_echo_rx_mode: assert property (@(posedge clk) disable iff (rst)
        s_echo |=> line_rx_en)
        else $error("echo rx dropped");

    // ----------------------------------------
    // pin to enable latency checks
    // ----------------------------------------
    // high dtr held four cycles turns echo tx on
    chk_echo_rise: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode == XM_DTR_ECHO && dtr_n) [*4] |=> line_tx_en)
        else $error("high dtr did not enable tx");

    // low dtr held turns dtr-controlled rx on
    chk_ctrl_rx_low: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode == XM_DTR_CTRL && !dtr_n) [*4] |=> (line_rx_en && !line_tx_en))
        else $error("low dtr did not enable rx");

    // high dtr held turns dtr-controlled rx off
    chk_ctrl_rx_high: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode == XM_DTR_CTRL && dtr_n) [*4] |=> (!line_rx_en && line_tx_en))
        else $error("high dtr did not disable rx");

    // ready held turns auto tx on, rx off
    chk_auto_ready_lat: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode == XM_TX_AUTO && tx_ready_line) [*4] |=> (line_tx_en && !line_rx_en))
        else $error("ready did not reach enables");

    // ready low held turns auto rx on, tx off
    chk_auto_idle_lat: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode == XM_TX_AUTO && !tx_ready_line) [*4] |=> (!line_tx_en && line_rx_en))
        else $error("idle ready did not reach enables");

    // four-wire ignores both pins
    chk_four_pins_ignored: assert property (@(posedge clk) disable iff (rst)
        (st_r.mode == XM_FOUR_WIRE && !dtr_n && !tx_ready_line) [*4] |=> (line_tx_en && line_rx_en))
        else $error("four-wire reacted to pins");

    // ----------------------------------------
    // open to enable latency checks
    // ----------------------------------------
    // four-wire enables two edges after open
    chk_lat_four: assert property (@(posedge clk) disable iff (rst)
        (port_open && mode_sel == MODE_FOUR_WIRE) ##1 1'b1 |=> (line_tx_en && line_rx_en))
        else $error("four-wire open latency wrong");

    // echo rx on two edges after open
    chk_lat_echo: assert property (@(posedge clk) disable iff (rst)
        (port_open && mode_sel == MODE_DTR_ECHO) ##1 1'b1 |=> line_rx_en)
        else $error("echo open latency wrong");

    // dtr-controlled rx enable two edges after open
    chk_lat_ctrl: assert property (@(posedge clk) disable iff (rst)
        (port_open && mode_sel == MODE_DTR_CTRL) ##1 1'b1 |=> (line_rx_en == !$past(st_r.sync2.dtr_n)))
        else $error("dtr-controlled open latency wrong");

    // auto tx enable two edges after open
    chk_lat_auto: assert property (@(posedge clk) disable iff (rst)
        (port_open && mode_sel == MODE_TX_AUTO) ##1 1'b1 |=> (line_tx_en == $past(st_r.sync2.tx_ready_line)))
        else $error("auto open latency wrong");

endmodule
`default_nettype wire

// ===== tb/line_xcvr_model.sv
`timescale 1ns/1ps
`default_nettype none
module line_xcvr_model (
    input wire logic tx_en,
    input wire logic rx_en,
    input wire logic tx_bit,
    input wire logic far_bit,
    output logic rx_bit
);
    // bus level: own driver wins while enabled
    logic bus;
    assign bus = tx_en ? tx_bit : far_bit;
    // receiver off: output floats, shown as inverse of own drive
    assign rx_bit = rx_en ? bus : ~tx_bit;
endmodule
`default_nettype wire

// ===== tb/xcvr_enable_ctl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module xcvr_enable_ctl_tb;
    import xcvr_ctl_pkg::*;
    logic clk, rst, port_open, dtr_n, tx_ready_line, tx_bit, far_bit;
    logic [MODE_W-1:0] mode_sel;
    logic line_tx_en, line_rx_en, mode_bad, rx_bit;
    int n_errors = 0;
    int n_checks = 0;
    xcvr_enable_ctl i_xcvr_enable_ctl (.clk(clk), .rst(rst), .port_open(port_open),
        .mode_sel(mode_sel), .dtr_n(dtr_n), .tx_ready_line(tx_ready_line),
        .line_tx_en(line_tx_en), .line_rx_en(line_rx_en), .mode_bad(mode_bad));
    line_xcvr_model i_line_xcvr_model (.tx_en(line_tx_en), .rx_en(line_rx_en),
        .tx_bit(tx_bit), .far_bit(far_bit), .rx_bit(rx_bit));
    // ----------------------------------------
    // clock and verdict
    // ----------------------------------------
    always #12.5 clk = ~clk;
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    // all enables and the echo seen through the transceiver
    task automatic chk_all(input logic tx, input logic rx, input logic bad);
        chk("line_tx_en", tx, line_tx_en);
        chk("line_rx_en", rx, line_rx_en);
        chk("mode_bad", bad, mode_bad);
        chk("rx_bit", rx ? (tx ? tx_bit : far_bit) : ~tx_bit, rx_bit);
    endtask
    // scenario: reset in mid-run returns to four-wire
    task automatic reset_midrun;
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        chk_all(1'b1, 1'b1, 1'b0);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk_all(1'b1, 1'b1, 1'b0);
    endtask
    // ----------------------------------------
    // scenario: open with a code, set controls, judge
    // ----------------------------------------
    task automatic open_and_check(input logic [MODE_W-1:0] code, input logic d, input logic r,
                                  input logic tx, input logic rx, input logic bad);
        @(negedge clk);
        port_open = 1'b1;
        mode_sel = code;
        dtr_n = d;
        tx_ready_line = r;
        far_bit = ~far_bit;
        @(negedge clk);
        port_open = 1'b0;
        repeat (4) @(negedge clk);
        chk_all(tx, rx, bad);
    endtask
    initial begin
        #100us;
        n_errors++;
        print_verdict();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        port_open = 1'b0;
        mode_sel = 32'h0000_0000;
        dtr_n = 1'b0;
        tx_ready_line = 1'b0;
        tx_bit = 1'b1;
        far_bit = 1'b0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk_all(1'b1, 1'b1, 1'b0);
        open_and_check(MODE_FOUR_WIRE, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        open_and_check(MODE_DTR_ECHO, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        open_and_check(MODE_DTR_ECHO, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        open_and_check(MODE_DTR_CTRL, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        open_and_check(MODE_DTR_CTRL, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        open_and_check(MODE_TX_AUTO, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        open_and_check(MODE_TX_AUTO, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        open_and_check(32'h0000_0084, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
        reset_midrun();
        open_and_check(MODE_FOUR_WIRE, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
